// File: hw/swdt_regs.vh
// Operation
// RULE1: Every reset leaves watchdog enabled, 1 kHz clock, longest timeout of 1024 counts.
// RULE2: Timeout select 00 disables the watchdog; no reset is ever generated.
// RULE3: Writing 0x55 then 0xAA to service register clears counter, restarts period.
// RULE4: Service register writes store nothing; they only act as key events.
// RULE5: Counter reaching selected overflow count before service issues a system reset.
// RULE6: Writing any other value to the service register resets the system at once.
// RULE7: Clock select 0 counts 1 kHz ticks, 1 counts bus clock edges.
// RULE8: On 1 kHz clock, timeout 01/10/11 overflow at 32, 256, 1024 counts.
// RULE9: On bus clock, timeout 01/10/11 overflow at 2^13, 2^16, 2^18 cycles.
// RULE10: Bus clock with window enable accepts service only in last quarter of period.
// RULE11: In window mode a service write before the window opens resets the chip.
// RULE12: On 1 kHz clock window enable is ignored; service accepted any time.
// RULE13: Control register takes only its first write; that write clears the counter.
// RULE14: Software should write control once at start to lock the settings.
// RULE15: Software should not service the watchdog from an interrupt handler.
// RULE16: On bus clock, counter holds during debug and stop, resumes afterwards.
// RULE17: On 1 kHz clock, counter clears on debug or stop entry, restarts at zero.
// RULE18: Very-low-leakage stop entry disables watchdog until the next reset.
// RULE19: A lone 0xAA without preceding 0x55 does not restart the period.
`ifndef SWDT_REGS_VH
`define SWDT_REGS_VH

// Register byte offsets
`define SWDT_OFS_CONTROL      12'h000
`define SWDT_OFS_SERVICE      12'h004
`define SWDT_OFS_STATUS       12'h008
`define SWDT_OFS_MASK         12'h00C
`define SWDT_OFS_COUNT        12'h010

// Control field positions
`define SWDT_CTL_WINDOW_BIT   0
`define SWDT_CTL_CLKSEL_BIT   1
`define SWDT_CTL_TSEL_LO      2
`define SWDT_CTL_TSEL_HI      3
`define SWDT_CTL_LOCKED_BIT   4

// Control reset values
`define SWDT_RST_WINDOW       1'b0
`define SWDT_RST_CLKSEL       1'b0
`define SWDT_RST_TSEL         2'h3

// Status / mask bit positions
`define SWDT_EV_SERVICED      0
`define SWDT_EV_BAD_KEY       1
`define SWDT_EV_EARLY         2
`define SWDT_EV_OVERFLOW      3
`define SWDT_EV_WIDTH         4

// Service keys
`define SWDT_KEY_ARM          8'h55
`define SWDT_KEY_FIRE         8'hAA

// Slow clock rate and timeouts in milliseconds
`define SWDT_LPO_HZ           1000
`define SWDT_LPO_T1_MS        32
`define SWDT_LPO_T2_MS        256
`define SWDT_LPO_T3_MS        1024
`define SWDT_LPO_CNT1         (`SWDT_LPO_T1_MS * `SWDT_LPO_HZ / 1000)
`define SWDT_LPO_CNT2         (`SWDT_LPO_T2_MS * `SWDT_LPO_HZ / 1000)
`define SWDT_LPO_CNT3         (`SWDT_LPO_T3_MS * `SWDT_LPO_HZ / 1000)

// Bus clock overflow counts and window openings
`define SWDT_BUS_CNT1         8192
`define SWDT_BUS_CNT2         65536
`define SWDT_BUS_CNT3         262144
`define SWDT_BUS_WIN1         6144
`define SWDT_BUS_WIN2         49152
`define SWDT_BUS_WIN3         196608

`endif

// File: hw/swdt_top.v
// The implementer's own choices: the APB slave port and the placing of the registers.
`include "swdt_regs.vh"

module swdt_top #(
  parameter integer CNT_W    = 18,
  parameter integer BUS_CNT1 = `SWDT_BUS_CNT1,
  parameter integer BUS_CNT2 = `SWDT_BUS_CNT2,
  parameter integer BUS_CNT3 = `SWDT_BUS_CNT3,
  parameter integer BUS_WIN1 = `SWDT_BUS_WIN1,
  parameter integer BUS_WIN2 = `SWDT_BUS_WIN2,
  parameter integer BUS_WIN3 = `SWDT_BUS_WIN3
) (
  input  wire        clk,
  input  wire        reset,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output reg         pslverr,
  input  wire        tick_1khz,
  input  wire        debug_mode,
  input  wire        stop_mode,
  input  wire        very_low_leakage_stop_modes,
  output reg         system_reset_req,
  output wire        irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Constants at counter width

  // Slow clock limits as integers, cut to width below
  localparam integer   LPO_CNT1 = `SWDT_LPO_CNT1;
  localparam integer   LPO_CNT2 = `SWDT_LPO_CNT2;
  localparam integer   LPO_CNT3 = `SWDT_LPO_CNT3;

  // Limits and openings at counter width plus one
  localparam [CNT_W:0] LPO_LIM1 = LPO_CNT1[CNT_W:0];
  localparam [CNT_W:0] LPO_LIM2 = LPO_CNT2[CNT_W:0];
  localparam [CNT_W:0] LPO_LIM3 = LPO_CNT3[CNT_W:0];
  localparam [CNT_W:0] BUS_LIM1 = BUS_CNT1[CNT_W:0];
  localparam [CNT_W:0] BUS_LIM2 = BUS_CNT2[CNT_W:0];
  localparam [CNT_W:0] BUS_LIM3 = BUS_CNT3[CNT_W:0];
  localparam [CNT_W:0] BUS_OPN1 = BUS_WIN1[CNT_W:0];
  localparam [CNT_W:0] BUS_OPN2 = BUS_WIN2[CNT_W:0];
  localparam [CNT_W:0] BUS_OPN3 = BUS_WIN3[CNT_W:0];
  localparam [CNT_W:0] ONE_W    = {{CNT_W{1'b0}}, 1'b1};

  ////////////////////////////////////////////////////////////////////////////
  // State

  reg                      window_enable;
  reg                      clock_source_select;
  reg  [1:0]               timeout_select;
  reg                      ctrl_locked;
  reg                      key_armed;
  reg                      vlls_off;
  reg  [CNT_W-1:0]         count;
  reg  [`SWDT_EV_WIDTH-1:0] status;
  reg  [`SWDT_EV_WIDTH-1:0] mask;
  reg  [`SWDT_EV_WIDTH-1:0] status_seen;

  reg  [CNT_W-1:0]         next_count;
  reg                      next_key_armed;
  reg  [`SWDT_EV_WIDTH-1:0] next_status;
  reg  [CNT_W:0]           limit;
  reg  [CNT_W:0]           win_open;
  reg  [31:0]              rd_mux;
  reg                      rd_hit;

  // Decode and datapath nets
  wire                     wr_access;
  wire                     rd_setup;
  wire                     rd_access;
  wire                     wr_ctrl;
  wire                     wr_service;
  wire                     rd_status;
  wire [7:0]               key;
  wire                     enabled;
  wire                     low_power_hold;
  wire                     count_step;
  wire                     windowed;
  wire                     in_window;
  wire                     svc_early;
  wire                     svc_bad;
  wire                     svc_accept;
  wire                     overflow;
  wire                     fire_reset;
  wire [`SWDT_EV_WIDTH-1:0] events;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  // Zero wait state slave
  // Reads need no wait since data is captured in setup
  assign pready     = 1'b1;
  assign wr_access  = psel & penable & pwrite;
  assign rd_setup   = psel & ~penable & ~pwrite;
  assign rd_access  = psel & penable & ~pwrite;
  assign wr_ctrl    = wr_access & (paddr == `SWDT_OFS_CONTROL);
  assign wr_service = wr_access & (paddr == `SWDT_OFS_SERVICE);
  assign rd_status  = rd_access & (paddr == `SWDT_OFS_STATUS);
  assign key        = pwdata[7:0];

  // Read data selection
  // Unmapped addresses read zero and raise the error flag
  always @*
  begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      `SWDT_OFS_CONTROL:
      begin
        rd_mux[`SWDT_CTL_WINDOW_BIT]                    = window_enable;
        rd_mux[`SWDT_CTL_CLKSEL_BIT]                    = clock_source_select;
        rd_mux[`SWDT_CTL_TSEL_HI:`SWDT_CTL_TSEL_LO]     = timeout_select;
        rd_mux[`SWDT_CTL_LOCKED_BIT]                    = ctrl_locked;
      end
      `SWDT_OFS_SERVICE:
        rd_mux = 32'h0000_0000; // Service register holds nothing
      `SWDT_OFS_STATUS:
        rd_mux[`SWDT_EV_WIDTH-1:0] = status;
      `SWDT_OFS_MASK:
        rd_mux[`SWDT_EV_WIDTH-1:0] = mask;
      `SWDT_OFS_COUNT:
        rd_mux[CNT_W-1:0] = count;
      default:
        rd_hit = 1'b0;
    endcase
  end

  // Read data captured in the setup cycle, error for unmapped addresses
  // Unmapped writes are dropped and flagged the same way
  always @(posedge clk)
  begin
    if (reset)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      if (rd_setup)
        prdata <= rd_mux;
      if (psel & ~penable)
        pslverr <= ~rd_hit;
      else if (~psel)
        pslverr <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write-once control register

  // RULE13 first write locks
  // RULE1 reset defaults
  always @(posedge clk)
  begin
    if (reset)
    begin
      window_enable       <= `SWDT_RST_WINDOW;
      clock_source_select <= `SWDT_RST_CLKSEL;
      timeout_select      <= `SWDT_RST_TSEL;
      ctrl_locked         <= 1'b0;
    end
    else if (wr_ctrl & ~ctrl_locked)
    begin
      window_enable       <= pwdata[`SWDT_CTL_WINDOW_BIT];
      clock_source_select <= pwdata[`SWDT_CTL_CLKSEL_BIT];
      timeout_select      <= pwdata[`SWDT_CTL_TSEL_HI:`SWDT_CTL_TSEL_LO];
      ctrl_locked         <= 1'b1;
    end
  end

  // Interrupt mask, freely writable
  // Mask changes never touch status
  always @(posedge clk)
  begin
    if (reset)
      mask <= {`SWDT_EV_WIDTH{1'b0}};
    else if (wr_access & (paddr == `SWDT_OFS_MASK))
      mask <= pwdata[`SWDT_EV_WIDTH-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timeout selection

  // RULE8 slow clock limits
  // RULE9 bus clock limits
  // Opening stays zero on the slow clock, so all counts are inside
  always @*
  begin
    limit    = LPO_LIM3;
    win_open = {(CNT_W+1){1'b0}};
    case ({clock_source_select, timeout_select})
      3'b001:
        limit = LPO_LIM1;
      3'b010:
        limit = LPO_LIM2;
      3'b011:
        limit = LPO_LIM3;
      3'b101:
      begin
        limit    = BUS_LIM1;
        win_open = BUS_OPN1;
      end
      3'b110:
      begin
        limit    = BUS_LIM2;
        win_open = BUS_OPN2;
      end
      3'b111:
      begin
        limit    = BUS_LIM3;
        win_open = BUS_OPN3;
      end
      default:
        limit = LPO_LIM3; // Disabled setting, limit unused
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable, stepping and window

  // RULE2 timeout 00 disables
  // RULE18 leakage stop disables
  assign enabled = (timeout_select != 2'b00) & ~vlls_off;

  // Debug or stop mode, very-low-leakage stop not included
  assign low_power_hold = debug_mode | stop_mode;

  // Bus clock steps each edge, slow clock only on a tick
  // RULE7 clock source choice
  // RULE16 bus clock holds in low power
  assign count_step = enabled & ~low_power_hold & (clock_source_select | tick_1khz);

  // RULE10 last quarter window
  // RULE12 no window on slow clock
  assign windowed  = clock_source_select & window_enable;
  assign in_window = ~windowed | ({1'b0, count} >= win_open);

  ////////////////////////////////////////////////////////////////////////////
  // Service key decode

  // RULE4 keys are events only
  // RULE11 early write resets
  assign svc_early = enabled & wr_service & ~in_window;

  // RULE6 wrong key resets
  assign svc_bad = enabled & wr_service & (key != `SWDT_KEY_ARM) & (key != `SWDT_KEY_FIRE);

  // RULE3 arm then fire
  // RULE19 lone fire ignored
  assign svc_accept = enabled & wr_service & in_window & key_armed & (key == `SWDT_KEY_FIRE);

  // RULE5 overflow detection
  // Accept wins over overflow in the same cycle
  assign overflow = count_step & ~svc_accept & ({1'b0, count} == (limit - ONE_W));

  // Any fault asks for the chip reset
  assign fire_reset = svc_early | svc_bad | overflow;

  // Arming tracks the last key written
  always @*
  begin
    next_key_armed = key_armed;
    if (wr_service)
      next_key_armed = enabled & in_window & (key == `SWDT_KEY_ARM);
    if (wr_ctrl & ~ctrl_locked)
      next_key_armed = 1'b0;
  end

  // Arming register
  always @(posedge clk)
  begin
    if (reset)
      key_armed <= 1'b0;
    else
      key_armed <= next_key_armed;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter

  // Next count, clear sources before stepping
  always @*
  begin
    next_count = count;
    // RULE13 control write clears counter
    if (wr_ctrl & ~ctrl_locked)
      next_count = {CNT_W{1'b0}};
    // RULE3 service restarts period
    else if (svc_accept)
      next_count = {CNT_W{1'b0}};
    // RULE17 slow clock clears in low power
    else if (low_power_hold & ~clock_source_select)
      next_count = {CNT_W{1'b0}};
    else if (~enabled)
      next_count = {CNT_W{1'b0}};
    else if (count_step)
      next_count = count + {{(CNT_W-1){1'b0}}, 1'b1};
  end

  // Counter register
  always @(posedge clk)
  begin
    if (reset)
      count <= {CNT_W{1'b0}};
    else
      count <= next_count;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Low leakage stop latch and reset request

  // RULE18 disabled until next reset
  // Only a reset clears the latch, as on wake-up
  always @(posedge clk)
  begin
    if (reset)
      vlls_off <= 1'b0;
    else if (very_low_leakage_stop_modes)
      vlls_off <= 1'b1;
  end

  // Request holds until the system reset arrives
  always @(posedge clk)
  begin
    if (reset)
      system_reset_req <= 1'b0;
    else if (fire_reset)
      system_reset_req <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status

  // One status bit per event, in register order
  assign events = {overflow, svc_early, svc_bad, svc_accept};

  // Status bits seen by the read, captured with the read data
  always @(posedge clk)
  begin
    if (reset)
      status_seen <= {`SWDT_EV_WIDTH{1'b0}};
    else if (rd_setup)
      status_seen <= status;
  end

  // Read clears only bits it reported, so a setup-cycle event survives
  always @*
  begin
    next_status = status;
    if (rd_status)
      next_status = status & ~status_seen;
    next_status = next_status | events;
  end

  // Status register, a new event wins over the clear
  always @(posedge clk)
  begin
    if (reset)
      status <= {`SWDT_EV_WIDTH{1'b0}};
    else
      status <= next_status;
  end

  // Level interrupt while any unmasked bit is set
  assign irq = |(status & mask);

endmodule // swdt_top

// File: verif/swdt_chk.sv
module swdt_chk (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        debug_mode,
  input wire logic        stop_mode,
  input wire logic        very_low_leakage_stop_modes,
  input wire logic        system_reset_req,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       locked;
  logic       quiet;
  logic [3:0] cfg;
  wire        acc  = psel && penable;
  wire        svc  = acc && pwrite && paddr == 12'h004;
  wire        cw   = acc && pwrite && paddr == 12'h000 && !locked;
  wire        hold = debug_mode || stop_mode;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  // Settings in force and whether resets are off
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      locked <= 1'b0;
      quiet  <= 1'b0;
      cfg    <= 4'hC;
    end
    else
    begin
      if (cw)
      begin
        locked <= 1'b1;
        cfg    <= pwdata[3:0];
      end
      quiet <= quiet || very_low_leakage_stop_modes || (cw && pwdata[3:2] == 2'b00);
    end
  end
  ////////////////////////////////////////
  AST_RST_VAL: assert property ($fell(reset) |-> !system_reset_req && !irq)
    else $error("outputs not cleared by reset");
  AST_CTL_READ: assert property (acc && !pwrite && paddr == 12'h000 |-> prdata[4:0] == {locked, cfg})
    else $error("control readback wrong");
  AST_STICKY: assert property (system_reset_req |=> system_reset_req)
    else $error("reset request dropped");
  AST_BAD_KEY: assert property (svc && !quiet && pwdata[7:0] != 8'h55 && pwdata[7:0] != 8'hAA
    |=> system_reset_req)
    else $error("wrong key did not reset");
  AST_QUIET: assert property (quiet && !system_reset_req |=> !system_reset_req)
    else $error("reset while disabled");
  AST_SVC_READ: assert property (acc && !pwrite && paddr == 12'h004 |-> prdata == 32'h0)
    else $error("service register not zero");
  AST_SLOW_HOLD: assert property (acc && !pwrite && paddr == 12'h010 && !cfg[1] && hold
    && $past(hold) && $past(hold, 2) && $past(hold, 3) |-> prdata == 32'h0)
    else $error("slow counter not held at zero");
  AST_SLOW_ARM: assert property (svc && pwdata[7:0] == 8'h55 && !cfg[1] && !system_reset_req
    |=> !system_reset_req)
    else $error("first key reset on slow clock");
endmodule // swdt_chk

// File: verif/swdt_tb_top.sv
module swdt_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic        tick_1khz = 0, debug_mode = 0, stop_mode = 0, very_low_leakage_stop_modes = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd_val, lf = 32'hdab7;
  logic        pready, pslverr, system_reset_req, irq;
  logic [3:0]  c;
  int          n_errors = 0, tests_run = 0, n;
  // Longest window opening left at default; no test services that setting
  swdt_top #(.BUS_CNT1(64), .BUS_CNT2(128), .BUS_CNT3(256), .BUS_WIN1(48), .BUS_WIN2(96))
    u_swdt_top (.*);
  // Clock and a slow tick every fourth cycle
  initial
  begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) tick_1khz <= ($time / 50) % 4 == 0;
  ////////////////////////////////////////
  function logic [31:0] lfsr(input logic [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Expected overflow span in clocks
  function int lim(input logic [3:0] k);
    lim = k[1] ? 32 << k[3:2] : 4 * (k[3:2] == 1 ? 32 : k[3:2] == 2 ? 256 : 1024);
  endfunction
  task chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1;
    penable <= 0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd_val = prdata;
  endtask
  task key(input logic [7:0] k);
    xfer(1, 12'h004, {24'h0, k});
  endtask
  // Release the bus, wait for a reset request or m clocks
  task wt(input int m);
    psel    <= 0;
    penable <= 0;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (system_reset_req !== 1'b1 && n < m);
  endtask
  task rst();
    $display("Step done at %0t", $time);
    reset <= 1;
    repeat (2) @(posedge clk);
    reset <= 0;
    @(posedge clk);
  endtask
  task final_report();
    $display("Checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
  begin
    #3_000_000;
    n_errors++;
    final_report();
  end
  // Main sequence
  initial
  begin
    rst();
    xfer(0, 12'h000, 0);
    chk(rd_val, 32'hC);
    xfer(0, 12'h004, 0);
    chk(rd_val, 0);
    xfer(0, 12'h020, 0);
    chk(pslverr, 1);
    xfer(1, 12'h00C, 8);
    wt(5000);
    chk(n > 4080 && n < 4104, 1);
    for (int i = 0; i < 6; i++)
    begin
      rst();
      c = {2'(i % 3 + 1), i > 2, 1'b1};
      xfer(1, 12'h00C, {28'h0, i[0], 3'h0});
      xfer(1, 12'h000, {28'h0, c});
      wt(5000);
      chk(n > lim(c) - 8 && n < lim(c) + 8, 1);
      chk(irq, i[0]);
      xfer(0, 12'h008, 0);
      chk(rd_val, 32'h8);
      wt(1);
      chk(irq, 0);
    end
    rst();
    xfer(1, 0, 6);
    repeat (4)
    begin
      lf = lfsr(lf);
      wt(20 + lf[3:0]);
      key(8'h55);
      key(8'hAA);
    end
    chk(system_reset_req, 0);
    xfer(0, 12'h008, 0);
    chk(rd_val, 1);
    wt(10);
    key(8'hAA);
    wt(100);
    chk(n > 44 && n < 58, 1);
    for (int i = 0; i < 2; i++)
    begin
      rst();
      lf = lfsr(lf);
      if (i)
        key(8'h55);
      key({lf[7:2], 2'b11});
      xfer(0, 12'h008, 0);
      chk(rd_val, 32'h2);
      wt(3);
      chk(system_reset_req, 1);
    end
    for (int i = 0; i < 2; i++)
    begin
      rst();
      xfer(1, 0, 7);
      wt(i ? 52 : 40);
      key(8'h55);
      key(8'hAA);
      xfer(0, 12'h008, 0);
      chk(rd_val, i ? 32'h1 : 32'h4);
      wt(30);
      chk(system_reset_req, !i);
    end
    for (int i = 0; i < 2; i++)
    begin
      rst();
      xfer(1, 0, i ? 2 : 5);
      wt(i ? 300 : 10);
      key(8'h55);
      key(i ? 8'h12 : 8'hAA);
      wt(10);
      chk(system_reset_req, 0);
    end
    rst();
    xfer(1, 0, 6);
    xfer(1, 0, 0);
    xfer(0, 0, 0);
    chk(rd_val, 32'h16);
    wt(100);
    chk(n > 52 && n < 68, 1);
    rst();
    xfer(1, 0, 6);
    wt(30);
    debug_mode <= 1;
    wt(200);
    chk(system_reset_req, 0);
    debug_mode <= 0;
    wt(100);
    chk(n > 26 && n < 40, 1);
    rst();
    xfer(1, 0, 5);
    wt(100);
    stop_mode <= 1;
    wt(300);
    xfer(0, 12'h010, 0);
    chk(rd_val, 0);
    stop_mode <= 0;
    wt(200);
    chk(n > 118 && n < 138, 1);
    rst();
    very_low_leakage_stop_modes <= 1;
    wt(1);
    very_low_leakage_stop_modes <= 0;
    key(8'h12);
    wt(4200);
    chk(system_reset_req, 0);
    rst();
    key(8'h12);
    wt(3);
    chk(system_reset_req, 1);
    final_report();
  end
endmodule // swdt_tb_top
bind swdt_top swdt_chk u_swdt_chk (.*);
